// [hw/msc_codec.sv]
`timescale 1ns/10ps
module msc_codec (
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic [4:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	input wire logic [3:0] I_AVS_BYTEENABLE,
	output logic [31:0] O_AVS_READDATA,
	output logic O_AVS_WAITREQUEST,
	output logic O_IRQ,
	input wire logic I_TX_DATA,
	input wire logic I_TX_ENCODE_ENABLE,
	output logic O_TX_BIT_CLOCK,
	output logic O_TX_POS,
	output logic O_TX_NEG,
	input wire logic I_IDLE_LEVEL_SELECT,
	input wire logic I_LOOPBACK_SELECT,
	input wire logic I_RX_POS,
	input wire logic I_RX_NEG,
	input wire logic I_COLLISION_IN_POS,
	input wire logic I_COLLISION_IN_NEG,
	output logic O_RX_DATA,
	output logic O_RECOVERED_CLOCK,
	output logic O_CARRIER_PRESENT,
	output logic O_COLLISION
);
	logic [7:0] ctrl_q;
	logic [3:0] irq_stat_q;
	logic [3:0] irq_en_q;
	logic [3:0] irq_clr;
	logic [3:0] irq_ev;
	logic ack_q;
	logic wr_go;
	logic rd_first;
	logic [7:0] rd_mux;
	logic sel_ctrl;
	logic sel_status;
	logic sel_istat;
	logic sel_ien;
	logic sel_iclr;
	logic loop_w;
	logic enc_line;
	logic enc_drive;
	logic enc_done;
	logic dec_level;
	logic rx_locked;
	logic crs_prev_q;
	logic col_lvl;
	logic col_prev_q;
	logic col_edge;
	logic col_ok;
	logic [5:0] col_cnt_q;
	logic [5:0] hold_q;
	logic [1:0] run_q;
	logic col_prev_flag_q;

	// Software loopback adds to the pin so a board test can run without strapping.
	assign loop_w = I_LOOPBACK_SELECT | ctrl_q[msc_pkg::CTRL_LOOP_BIT];
	// The decoder input is forced high when the encoder stops driving, like its tail cell, so idle in loopback adds no edge.
	assign dec_level = loop_w ? (enc_drive ? enc_line : 1'b1) : (I_RX_POS & ~I_RX_NEG);

	msc_tx_enc u_tx (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_data(I_TX_DATA),
		.i_enable(I_TX_ENCODE_ENABLE),
		.o_bit_clock(O_TX_BIT_CLOCK),
		.o_line(enc_line),
		.o_drive(enc_drive),
		.o_done(enc_done)
	);

	msc_rx_dec u_rx (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_level(dec_level),
		.o_data(O_RX_DATA),
		.o_clock(O_RECOVERED_CLOCK),
		.o_carrier(O_CARRIER_PRESENT),
		.o_locked(rx_locked)
	);

	// Collision tone: count half periods and accept those inside the band.
	assign col_lvl = ~loop_w & I_COLLISION_IN_POS & ~I_COLLISION_IN_NEG;
	assign col_edge = col_lvl ^ col_prev_q;
	assign col_ok = col_edge & (col_cnt_q >= msc_pkg::COL_HALF_MIN_CNT - 6'h1)
		& (col_cnt_q <= msc_pkg::COL_HALF_MAX_CNT - 6'h1);

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			col_prev_q <= 1'b0;
			col_cnt_q <= 6'h0;
			hold_q <= 6'h3F;
			run_q <= 2'h0;
			O_COLLISION <= 1'b0;
		end else begin
			col_prev_q <= col_lvl;
			col_cnt_q <= col_edge ? 6'h0 : col_cnt_q + {5'h0, col_cnt_q != 6'h3F};
			hold_q <= col_ok ? 6'h0 : hold_q + {5'h0, hold_q != 6'h3F};
			if (col_ok) begin
				run_q <= run_q + {1'b0, run_q != 2'h3};
			end else if (col_edge || hold_q >= msc_pkg::COL_HOLD_CNT) begin
				run_q <= 2'h0;
			end
			if (loop_w || hold_q >= msc_pkg::COL_HOLD_CNT) begin
				O_COLLISION <= 1'b0;
			end else if (col_ok && run_q != 2'h0) begin
				O_COLLISION <= 1'b1;
			end
		end
	end

	// Line driver: data while framing outside loopback, else the selected idle level.
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_TX_POS <= 1'b0;
			O_TX_NEG <= 1'b0;
		end else if (enc_drive && !loop_w) begin
			O_TX_POS <= enc_line;
			O_TX_NEG <= ~enc_line;
		end else begin
			O_TX_POS <= ~I_IDLE_LEVEL_SELECT;
			O_TX_NEG <= 1'b0;
		end
	end

	// Register slave: every access waits exactly one cycle.
	assign O_AVS_WAITREQUEST = (I_AVS_READ | I_AVS_WRITE) & ~ack_q;
	assign wr_go = I_AVS_WRITE & ack_q & I_AVS_BYTEENABLE[0];
	assign rd_first = I_AVS_READ & ~ack_q;
	assign sel_ctrl = (I_AVS_ADDRESS == msc_pkg::REG_CTRL);
	assign sel_status = (I_AVS_ADDRESS == msc_pkg::REG_STATUS);
	assign sel_istat = (I_AVS_ADDRESS == msc_pkg::REG_IRQ_STATUS);
	assign sel_ien = (I_AVS_ADDRESS == msc_pkg::REG_IRQ_ENABLE);
	assign sel_iclr = (I_AVS_ADDRESS == msc_pkg::REG_IRQ_CLEAR);
	assign rd_mux = sel_ctrl ? ctrl_q :
		sel_status ? {3'h0, loop_w, enc_drive, rx_locked, O_COLLISION, O_CARRIER_PRESENT} :
		sel_istat ? {4'h0, irq_stat_q} :
		sel_ien ? {4'h0, irq_en_q} : 8'h00;
	assign irq_clr = (wr_go && sel_iclr) ? I_AVS_WRITEDATA[3:0] : 4'h0;
	assign irq_ev = {enc_done, O_COLLISION & ~col_prev_flag_q,
		crs_prev_q & ~O_CARRIER_PRESENT, O_CARRIER_PRESENT & ~crs_prev_q};
	assign O_IRQ = |(irq_stat_q & irq_en_q);

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ack_q <= 1'b0;
			O_AVS_READDATA <= 32'h00000000;
			ctrl_q <= msc_pkg::CTRL_RST;
			irq_en_q <= msc_pkg::IRQ_EN_RST;
			irq_stat_q <= 4'h0;
			crs_prev_q <= 1'b0;
			col_prev_flag_q <= 1'b0;
		end else begin
			ack_q <= (I_AVS_READ | I_AVS_WRITE) & ~ack_q;
			if (rd_first) begin
				O_AVS_READDATA <= {24'h000000, rd_mux};
			end
			if (wr_go && sel_ctrl) begin
				ctrl_q <= I_AVS_WRITEDATA[7:0];
			end
			if (wr_go && sel_ien) begin
				irq_en_q <= I_AVS_WRITEDATA[3:0];
			end
			// A new event wins over a clear in the same cycle.
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
			crs_prev_q <= O_CARRIER_PRESENT;
			col_prev_flag_q <= O_COLLISION;
		end
	end

	property p_col_drop;
		@(posedge I_CLK) disable iff (!I_RST_N)
		(col_cnt_q >= msc_pkg::COL_DROP_CNT - 6'h1) |-> !O_COLLISION;
	endproperty
	a_col_drop: assert property (p_col_drop) else $error("collision held past 350 ns");

	property p_col_set;
		@(posedge I_CLK) disable iff (!I_RST_N)
		col_ok && run_q != 2'h0 && !loop_w |=> O_COLLISION;
	endproperty
	a_col_set: assert property (p_col_set) else $error("collision not flagged");

	property p_loop_idle;
		@(posedge I_CLK) disable iff (!I_RST_N)
		loop_w && I_IDLE_LEVEL_SELECT |=> !O_TX_POS && !O_TX_NEG && !O_COLLISION;
	endproperty
	a_loop_idle: assert property (p_loop_idle) else $error("line active in loopback");

	property p_idle_sel;
		@(posedge I_CLK) disable iff (!I_RST_N)
		(!enc_drive || loop_w) && !I_IDLE_LEVEL_SELECT |=> O_TX_POS && !O_TX_NEG;
	endproperty
	a_idle_sel: assert property (p_idle_sel) else $error("wrong idle level");

	property p_loop_sel;
		@(posedge I_CLK) disable iff (!I_RST_N)
		I_LOOPBACK_SELECT && enc_drive |-> dec_level == enc_line;
	endproperty
	a_loop_sel: assert property (p_loop_sel) else $error("loopback path open");

	property p_bus_wait;
		@(posedge I_CLK) disable iff (!I_RST_N)
		$rose(I_AVS_READ) |-> O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST;
	endproperty
	a_bus_wait: assert property (p_bus_wait) else $error("bus answer late");

	c_col: cover property (@(posedge I_CLK) disable iff (!I_RST_N) $rose(O_COLLISION));
	c_crs: cover property (@(posedge I_CLK) disable iff (!I_RST_N) $fell(O_CARRIER_PRESENT));
	c_rxc: cover property (@(posedge I_CLK) disable iff (!I_RST_N) $rose(O_RECOVERED_CLOCK));
	c_txd: cover property (@(posedge I_CLK) disable iff (!I_RST_N) enc_done && O_IRQ);
endmodule : msc_codec

// [hw/msc_pkg.sv]
package msc_pkg;
	// Time base: the fabric clock period and the line bit time.
	localparam int CLK_PERIOD_NS = 10;
	localparam int BIT_TIME_NS = 100;
	localparam int BIT_CYC = BIT_TIME_NS / CLK_PERIOD_NS;
	localparam int HALF_CYC = BIT_CYC / 2;
	localparam logic [3:0] BIT_LAST = 4'(BIT_CYC - 1);
	localparam logic [3:0] HALF_CNT = 4'(HALF_CYC);
	// Carrier drops one and a half bit times after the last line edge.
	localparam int CRS_DROP_NS = 150;
	localparam logic [5:0] CRS_DROP_CNT = 6'(CRS_DROP_NS / CLK_PERIOD_NS);
	// A mid-cell edge comes at least three quarters of a bit after the previous one.
	localparam logic [3:0] MID_MIN_CNT = 4'((3 * BIT_CYC) / 4 - 1);
	localparam logic [2:0] LOCK_BITS = 3'h4;
	localparam int RXC_TAIL_BITS = 5;
	localparam logic [5:0] RXC_TAIL_CNT = 6'(RXC_TAIL_BITS * BIT_CYC);
	// Collision tone: 10 MHz +25% -15%, measured as half periods.
	localparam int COL_HALF_MIN_PS = 40000;
	localparam int COL_HALF_MAX_PS = 58824;
	localparam logic [5:0] COL_HALF_MIN_CNT =
		6'((COL_HALF_MIN_PS + CLK_PERIOD_NS * 1000 - 1) / (CLK_PERIOD_NS * 1000));
	localparam logic [5:0] COL_HALF_MAX_CNT =
		6'((COL_HALF_MAX_PS + CLK_PERIOD_NS * 1000 - 1) / (CLK_PERIOD_NS * 1000));
	localparam int COL_DROP_NS = 350;
	localparam logic [5:0] COL_DROP_CNT = 6'(COL_DROP_NS / CLK_PERIOD_NS);
	localparam logic [5:0] COL_HOLD_CNT = COL_DROP_CNT - 6'h3;
	// Register map, byte addresses.
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_STATUS = 5'h04;
	localparam logic [4:0] REG_IRQ_STATUS = 5'h08;
	localparam logic [4:0] REG_IRQ_ENABLE = 5'h0C;
	localparam logic [4:0] REG_IRQ_CLEAR = 5'h10;
	localparam int CTRL_LOOP_BIT = 0;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [3:0] IRQ_EN_RST = 4'h0;
	localparam int IRQ_CRS_RISE = 0;
	localparam int IRQ_CRS_FALL = 1;
	localparam int IRQ_COL_RISE = 2;
	localparam int IRQ_TX_DONE = 3;
endpackage : msc_pkg

// [hw/msc_rx_dec.sv]
`timescale 1ns/10ps
module msc_rx_dec (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_level,
	output logic o_data,
	output logic o_clock,
	output logic o_carrier,
	output logic o_locked
);
	logic prev_q;
	logic [5:0] gap_q;
	logic [3:0] mid_q;
	logic [3:0] phase_q;
	logic [3:0] phase_d;
	logic [2:0] lock_q;
	logic [5:0] tail_q;
	logic edge_w;
	logic accept;
	logic run;
	logic last_tail;

	// Line is oversampled at the fabric clock; edges near mid-cell carry the bits.
	assign edge_w = i_level ^ prev_q;
	assign accept = edge_w & (~o_carrier | (mid_q >= msc_pkg::MID_MIN_CNT));
	assign phase_d = (accept | (phase_q == msc_pkg::BIT_LAST)) ? 4'h0 : phase_q + 4'h1;
	assign run = o_carrier | (tail_q != 6'h0);
	// The clock stops on the edge where the tail count runs out, not one cycle later.
	assign last_tail = ~o_carrier & (tail_q == 6'h1);
	assign o_locked = (lock_q == msc_pkg::LOCK_BITS);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prev_q <= 1'b0;
			gap_q <= 6'h0;
			mid_q <= 4'h0;
			phase_q <= 4'h0;
			lock_q <= 3'h0;
			tail_q <= 6'h0;
			o_data <= 1'b0;
			o_clock <= 1'b0;
			o_carrier <= 1'b0;
		end else begin
			prev_q <= i_level;
			gap_q <= edge_w ? 6'h0 : gap_q + {5'h0, gap_q != 6'h3F};
			mid_q <= accept ? 4'h0 : mid_q + {3'h0, mid_q != 4'hF};
			phase_q <= phase_d;
			if (edge_w) begin
				o_carrier <= 1'b1;
			end else if (gap_q >= msc_pkg::CRS_DROP_CNT - 6'h1) begin
				o_carrier <= 1'b0;
			end
			if (o_carrier && !edge_w && gap_q >= msc_pkg::CRS_DROP_CNT - 6'h1) begin
				tail_q <= msc_pkg::RXC_TAIL_CNT;
			end else if (!o_carrier && tail_q != 6'h0) begin
				tail_q <= tail_q - 6'h1;
			end
			if (accept) begin
				o_data <= i_level;
			end
			if (!run) begin
				lock_q <= 3'h0;
			end else if (accept && !o_locked) begin
				lock_q <= lock_q + 3'h1;
			end
			o_clock <= o_locked & run & ~last_tail & (phase_d >= msc_pkg::HALF_CNT);
		end
	end

	property p_rx_data;
		@(posedge i_clk) disable iff (!i_rst_n)
		accept |=> o_data == $past(i_level);
	endproperty
	a_rx_data: assert property (p_rx_data) else $error("decoded bit wrong");

	property p_crs_drop;
		@(posedge i_clk) disable iff (!i_rst_n)
		!edge_w && (gap_q == msc_pkg::CRS_DROP_CNT - 6'h1) |=> !o_carrier;
	endproperty
	a_crs_drop: assert property (p_crs_drop) else $error("carrier held too long");

	property p_crs_hold;
		@(posedge i_clk) disable iff (!i_rst_n)
		edge_w |=> o_carrier [*8];
	endproperty
	a_crs_hold: assert property (p_crs_hold) else $error("carrier missing");

	property p_rxc_lock;
		@(posedge i_clk) disable iff (!i_rst_n)
		!o_locked |=> !o_clock;
	endproperty
	a_rxc_lock: assert property (p_rxc_lock) else $error("clock before lock");

	property p_rxc_tail;
		@(posedge i_clk) disable iff (!i_rst_n)
		!o_carrier && (tail_q == 6'h1) |=> !o_clock [*8];
	endproperty
	a_rxc_tail: assert property (p_rxc_tail) else $error("clock after tail");
endmodule : msc_rx_dec

// [hw/msc_tx_enc.sv]
`timescale 1ns/10ps
module msc_tx_enc (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_data,
	input wire logic i_enable,
	output logic o_bit_clock,
	output logic o_line,
	output logic o_drive,
	output logic o_done
);
	logic [3:0] phase_q;
	logic [3:0] phase_d;
	logic bit_q;
	logic active_q;
	logic tail_q;
	logic line_d;
	logic take;
	logic first_half;

	// The bit clock rises on the edge where the cell counter wraps.
	assign take = (phase_q == msc_pkg::BIT_LAST);
	assign phase_d = take ? 4'h0 : phase_q + 4'h1;
	assign first_half = (phase_q < msc_pkg::HALF_CNT);
	// A one is low then high, a zero high then low; the tail cell is high.
	assign line_d = tail_q | (active_q & (first_half ? ~bit_q : bit_q));

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			// Starting on the last phase gives a full five-cycle first high half.
			phase_q <= msc_pkg::BIT_LAST;
			o_bit_clock <= 1'b0;
			o_line <= 1'b0;
			o_drive <= 1'b0;
			o_done <= 1'b0;
			bit_q <= 1'b0;
			active_q <= 1'b0;
			tail_q <= 1'b0;
		end else begin
			phase_q <= phase_d;
			o_bit_clock <= (phase_d < msc_pkg::HALF_CNT);
			o_line <= line_d;
			o_drive <= active_q | tail_q;
			o_done <= take & ~i_enable & active_q;
			if (take) begin
				active_q <= i_enable;
				tail_q <= active_q & ~i_enable;
				if (i_enable) begin
					bit_q <= i_data;
				end
			end
		end
	end

	property p_tx_sample;
		@(posedge i_clk) disable iff (!i_rst_n)
		take && i_enable |=> (bit_q == $past(i_data)) && active_q;
	endproperty
	a_tx_sample: assert property (p_tx_sample) else $error("tx bit not sampled");

	property p_tx_manch;
		@(posedge i_clk) disable iff (!i_rst_n)
		take && i_enable |=> ##1 (o_line == !bit_q) ##5 (o_line == bit_q);
	endproperty
	a_tx_manch: assert property (p_tx_manch) else $error("bad manchester cell");

	property p_tx_end;
		@(posedge i_clk) disable iff (!i_rst_n)
		take && !i_enable && active_q |=> ##1 (o_line && o_drive) [*8];
	endproperty
	a_tx_end: assert property (p_tx_end) else $error("tail not high");

	property p_tx_bclk;
		@(posedge i_clk) disable iff (!i_rst_n)
		$rose(o_bit_clock) |-> o_bit_clock [*5] ##1 !o_bit_clock [*5] ##1 o_bit_clock;
	endproperty
	a_tx_bclk: assert property (p_tx_bclk) else $error("bit clock not 10 MHz");
endmodule : msc_tx_enc

// [testbench/msc_far_end.sv]
`timescale 1ns/10ps
module msc_far_end (
	input wire logic i_clk,
	input wire logic i_bit_clock,
	input wire logic i_tx_pos,
	input wire logic i_tx_neg,
	input wire logic i_rx_data,
	input wire logic i_rec_clock,
	input wire logic i_carrier,
	output logic o_tx_data,
	output logic o_tx_enable,
	output logic o_rx_pos,
	output logic o_rx_neg,
	output logic o_col_pos,
	output logic o_col_neg
);
	logic rx_busy = 1'b0;
	logic col_busy = 1'b0;
	logic bclk_q = 1'b0;
	logic rclk_q = 1'b0;
	logic [31:0] txcap_q = 32'h0;
	logic rxq[$];

	initial begin
		o_tx_data = 1'b0;
		o_tx_enable = 1'b0;
		o_rx_pos = 1'b0;
		o_rx_neg = 1'b0;
		o_col_pos = 1'b0;
		o_col_neg = 1'b0;
	end

	// Idle pairs carry equal levels that change every cycle, so no stale level reads as data.
	always @(posedge i_clk) begin
		bclk_q <= i_bit_clock;
		rclk_q <= i_rec_clock;
		if (!rx_busy) begin
			o_rx_pos <= ~o_rx_pos;
			o_rx_neg <= ~o_rx_pos;
		end
		if (!col_busy) begin
			o_col_pos <= ~o_col_pos;
			o_col_neg <= ~o_col_pos;
		end
		if (i_bit_clock != bclk_q && (i_tx_pos ^ i_tx_neg)) begin
			txcap_q <= {txcap_q[30:0], i_tx_pos};
		end
		if (i_rec_clock && !rclk_q && i_carrier) begin
			rxq.push_back(i_rx_data);
		end
	end

	task automatic bclk_rise();
		logic p;
		repeat (12) begin
			p = i_bit_clock;
			@(posedge i_clk);
			if (i_bit_clock && !p) break;
		end
	endtask : bclk_rise

	task automatic send_tx(input logic [31:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			bclk_rise();
			o_tx_enable <= 1'b1;
			o_tx_data <= v[i];
		end
		bclk_rise();
		o_tx_enable <= 1'b0;
	endtask : send_tx

	task automatic send_rx(input logic [23:0] v);
		@(negedge i_clk) rx_busy = 1'b1;
		for (int i = 23; i >= 0; i--) begin
			for (int h = 0; h < 2; h++) begin
				@(posedge i_clk);
				o_rx_pos <= h ? v[i] : ~v[i];
				o_rx_neg <= h ? ~v[i] : v[i];
				repeat (4) @(posedge i_clk);
			end
		end
		@(posedge i_clk);
		o_rx_pos <= 1'b0;
		o_rx_neg <= 1'b0;
		@(negedge i_clk) rx_busy = 1'b0;
	endtask : send_rx

	task automatic send_col(input int half, input int n);
		@(negedge i_clk) col_busy = 1'b1;
		repeat (n) begin
			@(posedge i_clk);
			o_col_pos <= ~o_col_pos;
			o_col_neg <= o_col_pos;
			repeat (half - 1) @(posedge i_clk);
		end
		@(negedge i_clk) col_busy = 1'b0;
	endtask : send_col

	// The byte follows the first pair of ones, which closes the preamble.
	task automatic get_byte(output logic [7:0] b);
		b = 'x;
		for (int i = 0; i + 9 < rxq.size(); i++) begin
			if (rxq[i] && rxq[i + 1]) begin
				for (int k = 0; k < 8; k++) b[7 - k] = rxq[i + 2 + k];
				break;
			end
		end
	endtask : get_byte
endmodule : msc_far_end

// [testbench/tb.sv]
`timescale 1ns/10ps
module tb;
	logic I_CLK, I_RST_N, I_AVS_READ, I_AVS_WRITE, I_IDLE_LEVEL_SELECT, I_LOOPBACK_SELECT;
	logic [4:0] I_AVS_ADDRESS;
	logic [31:0] I_AVS_WRITEDATA, O_AVS_READDATA, rd, cap;
	logic [3:0] I_AVS_BYTEENABLE;
	logic O_AVS_WAITREQUEST, O_IRQ, I_TX_DATA, I_TX_ENCODE_ENABLE, O_TX_BIT_CLOCK, O_TX_POS;
	logic O_TX_NEG, I_RX_POS, I_RX_NEG, I_COLLISION_IN_POS, I_COLLISION_IN_NEG, O_RX_DATA;
	logic O_RECOVERED_CLOCK, O_CARRIER_PRESENT, O_COLLISION;
	logic [7:0] b;
	logic [17:0] e;
	int error_cnt = 0;
	int tests_run = 0;
	int c, ones;
	int half_t[4] = '{5, 6, 9, 3};
	logic [7:0] tx_t[2] = '{8'h96, 8'h4B};

	msc_codec i_msc_codec (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_AVS_ADDRESS(I_AVS_ADDRESS),
		.I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
		.I_AVS_BYTEENABLE(I_AVS_BYTEENABLE), .O_AVS_READDATA(O_AVS_READDATA),
		.O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_IRQ(O_IRQ), .I_TX_DATA(I_TX_DATA),
		.I_TX_ENCODE_ENABLE(I_TX_ENCODE_ENABLE), .O_TX_BIT_CLOCK(O_TX_BIT_CLOCK),
		.O_TX_POS(O_TX_POS), .O_TX_NEG(O_TX_NEG), .I_IDLE_LEVEL_SELECT(I_IDLE_LEVEL_SELECT),
		.I_LOOPBACK_SELECT(I_LOOPBACK_SELECT), .I_RX_POS(I_RX_POS), .I_RX_NEG(I_RX_NEG),
		.I_COLLISION_IN_POS(I_COLLISION_IN_POS), .I_COLLISION_IN_NEG(I_COLLISION_IN_NEG),
		.O_RX_DATA(O_RX_DATA), .O_RECOVERED_CLOCK(O_RECOVERED_CLOCK),
		.O_CARRIER_PRESENT(O_CARRIER_PRESENT), .O_COLLISION(O_COLLISION));

	msc_far_end i_msc_far_end (.i_clk(I_CLK), .i_bit_clock(O_TX_BIT_CLOCK), .i_tx_pos(O_TX_POS),
		.i_tx_neg(O_TX_NEG), .i_rx_data(O_RX_DATA), .i_rec_clock(O_RECOVERED_CLOCK),
		.i_carrier(O_CARRIER_PRESENT), .o_tx_data(I_TX_DATA), .o_tx_enable(I_TX_ENCODE_ENABLE),
		.o_rx_pos(I_RX_POS), .o_rx_neg(I_RX_NEG), .o_col_pos(I_COLLISION_IN_POS),
		.o_col_neg(I_COLLISION_IN_NEG));

	initial begin
		I_CLK = 1'b0;
		forever #5 I_CLK = ~I_CLK;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t ns: seen %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic summarize();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : summarize

	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge I_CLK);
		I_AVS_ADDRESS <= a;
		I_AVS_WRITE <= wr;
		I_AVS_READ <= ~wr;
		I_AVS_WRITEDATA <= d;
		n = 0;
		do begin
			@(posedge I_CLK);
			n++;
		end while (O_AVS_WAITREQUEST !== 1'b0 && n < 50);
		if (O_AVS_WAITREQUEST !== 1'b0) begin
			error_cnt++;
			summarize();
		end
		rd = O_AVS_READDATA;
		I_AVS_READ <= 1'b0;
		I_AVS_WRITE <= 1'b0;
	endtask : bus

	// Counts rising edges and high samples of one of the two clock outputs.
	task automatic rises(input logic sel_tx, input int n);
		logic p, v;
		c = 0;
		ones = 0;
		p = sel_tx ? O_TX_BIT_CLOCK : O_RECOVERED_CLOCK;
		repeat (n) begin
			@(posedge I_CLK);
			v = sel_tx ? O_TX_BIT_CLOCK : O_RECOVERED_CLOCK;
			if (v && !p) c++;
			if (v) ones++;
			p = v;
		end
	endtask : rises

	initial begin
		#900000;
		error_cnt++;
		summarize();
	end

	initial begin
		I_RST_N = 1'b0;
		I_AVS_ADDRESS = 5'h00;
		I_AVS_READ = 1'b0;
		I_AVS_WRITE = 1'b0;
		I_AVS_WRITEDATA = 32'h0;
		I_AVS_BYTEENABLE = 4'hF;
		I_IDLE_LEVEL_SELECT = 1'b1;
		I_LOOPBACK_SELECT = 1'b0;
		repeat (20) @(posedge I_CLK);
		I_RST_N <= 1'b1;
		bus(1'b0, msc_pkg::REG_CTRL, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, msc_pkg::REG_IRQ_ENABLE, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, 5'h14, 32'h0);
		check(rd, 32'h0);
		bus(1'b1, msc_pkg::REG_IRQ_ENABLE, 32'h4);
		rises(1'b1, 40);
		check(32'(c), 32'd4);
		check(32'(ones), 32'd20);
		check({30'h0, O_TX_POS, O_TX_NEG}, 32'h0);
		I_IDLE_LEVEL_SELECT <= 1'b0;
		repeat (3) @(posedge I_CLK);
		check({30'h0, O_TX_POS, O_TX_NEG}, 32'h2);
		I_IDLE_LEVEL_SELECT <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			i_msc_far_end.send_col(half_t[k], 12);
			check({31'h0, O_COLLISION}, 32'(k < 2));
			repeat (36) @(posedge I_CLK);
			check({31'h0, O_COLLISION}, 32'h0);
		end
		bus(1'b0, msc_pkg::REG_IRQ_STATUS, 32'h0);
		check(rd, 32'h4);
		check({31'h0, O_IRQ}, 32'h1);
		bus(1'b1, msc_pkg::REG_IRQ_CLEAR, 32'h4);
		@(posedge I_CLK);
		check({31'h0, O_IRQ}, 32'h0);
		i_msc_far_end.rxq.delete();
		fork
			i_msc_far_end.send_rx({16'hAAAB, 8'hA5});
			begin
				repeat (120) @(posedge I_CLK);
				check({31'h0, O_CARRIER_PRESENT}, 32'h1);
			end
		join
		repeat (12) @(posedge I_CLK);
		check({31'h0, O_CARRIER_PRESENT}, 32'h1);
		repeat (8) @(posedge I_CLK);
		check({31'h0, O_CARRIER_PRESENT}, 32'h0);
		i_msc_far_end.get_byte(b);
		check({24'h0, b}, 32'hA5);
		rises(1'b0, 20);
		check(32'(c), 32'd2);
		repeat (40) @(posedge I_CLK);
		rises(1'b0, 100);
		check(32'(ones), 32'd0);
		for (int t = 0; t < 2; t++) begin
			i_msc_far_end.send_tx({24'h0, tx_t[t]}, 8);
			repeat (30) @(posedge I_CLK);
			e = 18'h0;
			for (int i = 7; i >= 0; i--) e = {e[15:0], ~tx_t[t][i], tx_t[t][i]};
			e = {e[15:0], 2'b11};
			check({14'h0, i_msc_far_end.txcap_q[17:0]}, {14'h0, e});
		end
		I_LOOPBACK_SELECT <= 1'b1;
		repeat (4) @(posedge I_CLK);
		cap = i_msc_far_end.txcap_q;
		i_msc_far_end.rxq.delete();
		fork
			i_msc_far_end.send_tx(32'h00AAAB3C, 24);
			i_msc_far_end.send_col(5, 150);
		join
		bus(1'b0, msc_pkg::REG_STATUS, 32'h0);
		check({31'h0, rd[4]}, 32'h1);
		repeat (40) @(posedge I_CLK);
		check(i_msc_far_end.txcap_q, cap);
		check({31'h0, O_COLLISION}, 32'h0);
		i_msc_far_end.get_byte(b);
		check({24'h0, b}, 32'h3C);
		I_LOOPBACK_SELECT <= 1'b0;
		bus(1'b1, msc_pkg::REG_CTRL, 32'h1);
		bus(1'b0, msc_pkg::REG_CTRL, 32'h0);
		check(rd, 32'h1);
		bus(1'b0, msc_pkg::REG_STATUS, 32'h0);
		check({31'h0, rd[4]}, 32'h1);
		bus(1'b1, msc_pkg::REG_CTRL, 32'h0);
		I_AVS_BYTEENABLE <= 4'hE;
		bus(1'b1, msc_pkg::REG_CTRL, 32'h1);
		I_AVS_BYTEENABLE <= 4'hF;
		bus(1'b0, msc_pkg::REG_CTRL, 32'h0);
		check(rd, 32'h0);
		summarize();
	end
endmodule : tb
